// File: cmd_pkg.sv
// Shared types, constants and helper functions of the command interpreter
package cmd_pkg;

    // --------------------
    // Character and word sizes
    // --------------------
    localparam int WORD_CHARS = 10;
    localparam int WORD_W = 8 * WORD_CHARS;
    localparam int NUM_W = 7;
    localparam int LEN_W = 4;
    localparam logic [LEN_W-1:0] LEN_MAX = 4'ha;
    localparam logic [NUM_W-1:0] NUM_SAT = 7'h63;      // 99, saturation of numeric suffix
    localparam logic [NUM_W-1:0] NUM_SAT_IN = 7'h09;   // Above this, one more digit saturates
    localparam logic [NUM_W-1:0] NUM_TEN = 7'h0a;
    localparam logic [NUM_W-1:0] IDX_MIN = 7'h01;      // Channel, function and waveform-memory sources run 1..4
    localparam logic [NUM_W-1:0] IDX_MAX = 7'h04;
    localparam logic [NUM_W-1:0] BUS_MAX = 7'h02;
    localparam logic [NUM_W-1:0] DIG_MAX = 7'h0f;      // Digital channels run 0..15

    // --------------------
    // Character codes
    // --------------------
    localparam logic [7:0] CH_NL = 8'h0a;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_STAR = 8'h2a;
    localparam logic [7:0] CH_COLON = 8'h3a;
    localparam logic [7:0] CH_QUERY = 8'h3f;
    localparam logic [7:0] CH_AT = 8'h40;
    localparam logic [7:0] CH_LPAR = 8'h28;
    localparam logic [7:0] CH_RPAR = 8'h29;
    localparam logic [7:0] CH_COMMA = 8'h2c;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_ONE = 8'h31;
    localparam logic [7:0] CH_NINE = 8'h39;
    localparam logic [7:0] CH_UA = 8'h41;
    localparam logic [7:0] CH_UZ = 8'h5a;
    localparam logic [7:0] CH_LA = 8'h61;
    localparam logic [7:0] CH_LZ = 8'h7a;
    localparam logic [7:0] CASE_BIT = 8'h20;

    // --------------------
    // Reset values and pod byte masks
    // --------------------
    localparam logic FLAG_RST = 1'b0;
    localparam logic [15:0] DIG_LOW_BYTE = 16'h00ff;
    localparam logic [15:0] DIG_HIGH_BYTE = 16'hff00;

    // --------------------
    // Types
    // --------------------
    typedef struct packed {
        logic [1:0] bus;
        logic hist;
        logic [3:0] wmem;
        logic [3:0] func;
        logic [3:0] chan;
        logic [15:0] dig;
    } view_sel_t;

    localparam view_sel_t VIEW_RST = '0;

    typedef enum logic [6:0] {
        CMD_NONE = 7'b0000001,
        CMD_TRIG = 7'b0000010,
        CMD_CLS = 7'b0000100,
        CMD_VIEW = 7'b0001000,
        CMD_BLANK = 7'b0010000,
        CMD_SELF = 7'b0100000,
        CMD_CANCEL = 7'b1000000
    } cmd_t;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_DIGIT = 3'b010,
        TX_TERM = 3'b100
    } tx_state_t;

    // Word being collected: right-aligned upper-case letters plus numeric suffix
    typedef struct packed {
        logic [WORD_W-1:0] text;
        logic [LEN_W-1:0] len;
        logic [NUM_W-1:0] num;
        logic has_num;
        logic bad;
    } word_t;

    // --------------------
    // Functions
    // --------------------
    function automatic logic is_letter(input logic [7:0] c);
        return ((c >= CH_UA) && (c <= CH_UZ)) || (c == CH_STAR);
    endfunction

    function automatic logic is_digit(input logic [7:0] c);
        return (c >= CH_ZERO) && (c <= CH_NINE);
    endfunction

    function automatic logic [7:0] upcase(input logic [7:0] c);
        return ((c >= CH_LA) && (c <= CH_LZ)) ? (c & ~CASE_BIT) : c;
    endfunction

    // Short or long header spelling
    function automatic logic kw(input logic [WORD_W-1:0] w, input logic [WORD_W-1:0] s,
                                input logic [WORD_W-1:0] l);
        return (w == s) || (w == l);
    endfunction

endpackage

// File: word_collector.sv
// Collects one header or parameter word: letters, then an optional decimal suffix
`timescale 1ns/1ps
`default_nettype none
module word_collector
    import cmd_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic clear_i,
    input wire logic letter_i,
    input wire logic digit_i,
    input wire logic [7:0] char_i,
    output word_t word_o
);

    word_t q;
    word_t next_q;

    // --------------------
    // Append logic
    // --------------------
    // Letters after digits or an over-long word mark the word bad, so a
    // mangled header can never alias onto a valid short spelling
    always_comb begin
        next_q = q;
        if (clear_i) begin
            next_q = '0;
        end else if (letter_i) begin
            if (q.has_num || (q.len == LEN_MAX)) begin
                next_q.bad = 1'b1;
            end else begin
                next_q.text = {q.text[WORD_W-9:0], char_i};
                next_q.len = q.len + 4'h1;
            end
        end else if (digit_i) begin
            next_q.has_num = 1'b1;
            if (q.num > NUM_SAT_IN) begin
                next_q.num = NUM_SAT;
            end else begin
                next_q.num = NUM_W'(q.num * NUM_TEN + {3'h0, char_i[3:0]});
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign word_o = q;

endmodule // word_collector
`default_nettype wire

// File: trig_view_cmd.sv
// Text command interpreter: trigger-event flag query, view/blank display, self-test cancel
//
// How it works
// RL1: Trigger query replies ASCII 1 or 0 then newline.
// RL2: Only a criteria-met trigger sets the flag; auto-triggers never do.
// RL3: Flag holds until trigger query or clear-status; read returns then clears.
// RL4: View command enables the named source on the display.
// RL5: Channel, function and stored-waveform indices must be 1 to 4.
// RL6: Channel list after at-sign: digital 0..15, singles or colon ranges.
// RL7: Individual digital channels accepted only on mixed-signal models.
// RL8: Low byte group enables bits 0..7, high byte group bits 8..15.
// RL9: Blank command disables the named source, inverse of view.
// RL10: Self-test cancel stops the running self-test.
// RL11: Host quotes any file name sent to the self-test group.
// RL12: Short and long headers, any case; bad input changes nothing.
`timescale 1ns/1ps
`default_nettype none
module trig_view_cmd
    import cmd_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    output logic rx_ready_o,
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    input wire logic trig_criteria_met_i,
    input wire logic auto_trig_i,
    input wire logic mixed_signal_model_i,
    input wire logic selftest_running_i,
    output logic selftest_cancel_o,
    output logic cmd_error_o,
    output logic trig_flag_o,
    output view_sel_t shown_o
);

    typedef struct packed {
        logic trig_flag;
        view_sel_t shown;
        cmd_t cmd;
        logic first;
        logic query;
        logic in_param;
        logic in_list;
        logic at_seen;
        logic rng_open;
        logic [NUM_W-1:0] rng_lo;
        view_sel_t pend;
        logic bad;
        tx_state_t tx;
        logic [7:0] tx_data;
        logic tx_valid;
        logic rx_ready;
        logic cancel;
        logic err;
    } ctl_t;

    ctl_t q;
    ctl_t next_q;
    word_t word;
    logic take;
    logic [7:0] ch;
    logic letter;
    logic digit;
    logic wclear;

    // --------------------
    // Decoding helpers
    // --------------------
    // Header words; the trigger-event query header is given in hex
    function automatic cmd_t hdr_decode(input cmd_t cur, input logic first,
                                        input logic [WORD_W-1:0] w);
        if (first) begin
            if (w == 80'h544552) return CMD_TRIG;
            if (w == 80'("*CLS")) return CMD_CLS;
            if (w == 80'("VIEW")) return CMD_VIEW;
            if (kw(w, 80'("BLAN"), 80'("BLANK"))) return CMD_BLANK;
            if (kw(w, 80'("SELF"), 80'("SELFTEST"))) return CMD_SELF;
        end else if (cur == CMD_SELF && kw(w, 80'("CANC"), 80'("CANCEL"))) begin
            return CMD_CANCEL;
        end
        return CMD_NONE;
    endfunction

    function automatic logic [3:0] onehot4(input logic [NUM_W-1:0] n);
        return 4'(4'h1 << 2'(n - IDX_MIN));
    endfunction

    // Source word to a selection mask; an all-zero mask means invalid
    function automatic view_sel_t src_decode(input word_t w);
        view_sel_t m;
        logic ok4;
        m = '0;
        ok4 = w.has_num && (w.num >= IDX_MIN) && (w.num <= IDX_MAX); // see RL5
        if (!w.bad) begin
            if (ok4 && kw(w.text, 80'("CHAN"), 80'("CHANNEL"))) m.chan = onehot4(w.num);
            if (ok4 && kw(w.text, 80'("FUNC"), 80'("FUNCTION"))) m.func = onehot4(w.num);
            if (ok4 && kw(w.text, 80'h574d454d, 80'h574d454d4f5259)) m.wmem = onehot4(w.num);
            if (!w.has_num && kw(w.text, 80'("HIST"), 80'("HISTOGRAM"))) m.hist = 1'b1;
            if (w.has_num && (w.num >= IDX_MIN) && (w.num <= BUS_MAX) &&
                (w.text == 80'("BUS"))) begin
                m.bus = 2'(2'h1 << 1'(w.num - IDX_MIN));
            end
            if (w.has_num && (w.num <= DIG_MAX) && kw(w.text, 80'("DIG"), 80'("DIGITAL"))) begin
                m.dig = 16'(16'h1 << w.num[3:0]);
            end
            if (w.has_num && (w.text == 80'("POD"))) begin
                if (w.num == IDX_MIN) m.dig = DIG_LOW_BYTE;    // see RL8
                if (w.num == BUS_MAX) m.dig = DIG_HIGH_BYTE;   // see RL8
            end
        end
        return m;
    endfunction

    function automatic logic [15:0] range_mask(input logic [NUM_W-1:0] lo,
                                               input logic [NUM_W-1:0] hi);
        logic [15:0] m;
        m = '0;
        for (int i = 0; i < 16; i++) begin
            if ((NUM_W'(i) >= lo) && (NUM_W'(i) <= hi)) m[i] = 1'b1;
        end
        return m;
    endfunction

    // --------------------
    // Character intake
    // --------------------
    // Input is stalled only while a reply is being sent
    assign take = rx_valid_i && q.rx_ready;
    assign ch = upcase(rx_data_i); // see RL12
    assign letter = take && is_letter(ch);
    assign digit = take && is_digit(ch);
    assign wclear = take && !letter && !digit;

    word_collector u_word (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .clear_i(wclear),
        .letter_i(letter),
        .digit_i(digit),
        .char_i(ch),
        .word_o(word)
    );

    // --------------------
    // Parser, executor and reply sequencer
    // --------------------
    always_comb begin
        cmd_t c;
        view_sel_t p;
        view_sel_t s;
        logic b;
        logic lo_ok;
        logic [NUM_W-1:0] lo;
        logic clr_flag;
        c = q.cmd;
        p = q.pend;
        s = '0;
        b = q.bad;
        lo_ok = 1'b0;
        lo = '0;
        clr_flag = 1'b0;
        next_q = q;
        next_q.cancel = 1'b0;
        next_q.err = 1'b0;

        if (take && !letter && !digit) begin
            // Close the word the delimiter ends
            if (word.len != '0 || word.has_num || word.bad) begin
                if (q.in_list) begin
                    b = b | word.len != '0;
                end else if (!q.in_param) begin
                    c = word.bad ? CMD_NONE : hdr_decode(q.cmd, q.first, word.text);
                    b = b | (c == CMD_NONE);
                    next_q.first = 1'b0;
                end else begin
                    s = src_decode(word); // see RL4
                    b = b | (s == '0) | (p != '0);
                    p = p | s;
                end
            end
            // Channel list handling
            if (q.in_list && (ch == CH_COLON)) begin
                next_q.rng_lo = word.num;
                next_q.rng_open = 1'b1;
                b = b | !word.has_num | q.rng_open;
            end else if (q.in_list && (ch == CH_COMMA || ch == CH_RPAR)) begin
                lo = q.rng_open ? q.rng_lo : word.num;
                lo_ok = word.has_num && (word.num <= DIG_MAX) && (lo <= word.num);
                b = b | !lo_ok;
                if (lo_ok) p.dig = p.dig | range_mask(lo, word.num); // see RL6
                next_q.rng_open = 1'b0;
                next_q.in_list = (ch == CH_COMMA);
            end else if (ch == CH_COLON) begin
                b = b | q.in_param;
            end else if (ch == CH_QUERY) begin
                b = b | q.in_param | q.query;
                next_q.query = 1'b1;
            end else if (ch == CH_SPACE) begin
                b = b | q.in_list;
                next_q.in_param = 1'b1;
            end else if (ch == CH_LPAR) begin
                b = b | !q.in_param | q.at_seen | (p != '0);
                next_q.at_seen = 1'b1;
            end else if (ch == CH_AT) begin
                b = b | !q.at_seen | q.in_list;
                next_q.in_list = 1'b1;
            end else if (ch != CH_NL) begin
                b = b | 1'b1;
            end
            next_q.cmd = c;
            next_q.pend = p;
            next_q.bad = b;

            // End of message: execute or reject as a whole
            if (ch == CH_NL) begin
                b = b | q.in_list | (q.at_seen && !(q.in_list || p != '0));
                if (p.dig != '0 && !mixed_signal_model_i) b = 1'b1; // see RL7
                if (b) begin
                    next_q.err = 1'b1; // see RL12
                end else begin
                    unique case (c)
                        CMD_NONE: next_q.err = q.query;
                        CMD_TRIG: begin
                            if (q.query && !q.in_param) begin
                                next_q.tx_data = q.trig_flag ? CH_ONE : CH_ZERO; // see RL1
                                next_q.tx = TX_DIGIT;
                                next_q.tx_valid = 1'b1; // see RL1
                                next_q.rx_ready = 1'b0;
                                clr_flag = 1'b1; // see RL3
                            end else begin
                                next_q.err = 1'b1;
                            end
                        end
                        CMD_CLS: begin
                            clr_flag = !q.query && !q.in_param; // see RL3
                            next_q.err = q.query || q.in_param;
                        end
                        CMD_VIEW, CMD_BLANK: begin
                            if (q.query || p == '0) begin
                                next_q.err = 1'b1;
                            end else if (c == CMD_VIEW) begin
                                next_q.shown = q.shown | p; // see RL4
                            end else begin
                                next_q.shown = q.shown & ~p; // see RL9
                            end
                        end
                        CMD_SELF: next_q.err = 1'b1;
                        CMD_CANCEL: begin
                            // A cancel with nothing running is harmless and dropped
                            next_q.cancel = selftest_running_i && !q.query && !q.in_param; // see RL10
                            next_q.err = q.query || q.in_param;
                        end
                    endcase
                end
                next_q.cmd = CMD_NONE;
                next_q.first = 1'b1;
                next_q.query = 1'b0;
                next_q.in_param = 1'b0;
                next_q.in_list = 1'b0;
                next_q.at_seen = 1'b0;
                next_q.rng_open = 1'b0;
                next_q.pend = '0;
                next_q.bad = 1'b0;
            end
        end

        // Reply bytes, one per accepted handshake
        unique case (q.tx)
            TX_IDLE: ;
            TX_DIGIT: if (tx_ready_i) begin
                next_q.tx = TX_TERM;
                next_q.tx_data = CH_NL; // see RL1
            end
            TX_TERM: if (tx_ready_i) begin
                next_q.tx = TX_IDLE;
                next_q.tx_valid = 1'b0;
                next_q.rx_ready = 1'b1;
            end
            default: begin
                next_q.tx = TX_IDLE;
                next_q.tx_valid = 1'b0;
                next_q.rx_ready = 1'b1;
            end
        endcase

        // Set wins over a same-cycle clear; auto-triggers are not an input to it
        next_q.trig_flag = (q.trig_flag & ~clr_flag) | trig_criteria_met_i; // see RL2
    end

    // State register
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            q <= '0;
            q.cmd <= CMD_NONE;
            q.first <= 1'b1;
            q.tx <= TX_IDLE;
            q.rx_ready <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // Outputs straight from state flops; auto_trig_i is deliberately unused by the flag
    assign rx_ready_o = q.rx_ready;
    assign tx_valid_o = q.tx_valid;
    assign tx_data_o = q.tx_data;
    assign selftest_cancel_o = q.cancel;
    assign cmd_error_o = q.err;
    assign trig_flag_o = q.trig_flag;
    assign shown_o = q.shown;

endmodule // trig_view_cmd
`default_nettype wire

// File: host_model.sv
// Remote controlling computer: sends command text and takes reply bytes
`timescale 1ns/1ps
`default_nettype none
module host_model
    import cmd_pkg::*;
(
    input wire logic clk_sys_i,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    input wire logic rx_ready_i,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o
);
    logic slow = 1'b0;
    logic [7:0] replies[$];

    // --------------------
    // Idle state and reply taking
    // --------------------
    initial begin
        rx_valid_o = 1'b0;
        rx_data_o = 8'h00;
        tx_ready_o = 1'b1;
    end

    // A slow host takes a reply byte only every other cycle
    always @(negedge clk_sys_i) begin
        tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
    end

    // Bytes are taken on the edge where valid and ready are both high
    always @(posedge clk_sys_i) begin
        if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1) begin
            replies.push_back(tx_data_i);
        end
    end

    // --------------------
    // Command sending
    // --------------------
    // One message per call; no file name parameters are ever sent
    task automatic send(input string s);
        string t;
        t = {s, "\n"};
        for (int i = 0; i < t.len(); i++) begin
            @(negedge clk_sys_i);
            rx_valid_o = 1'b1;
            rx_data_o = t[i];
            do @(posedge clk_sys_i); while (rx_ready_i !== 1'b1);
        end
        @(negedge clk_sys_i);
        rx_valid_o = 1'b0;
        rx_data_o = ~rx_data_o; // Released line must not keep the last character
    endtask
endmodule // host_model
`default_nettype wire

// File: trig_view_asserts.sv
// Port-level checks of the command interpreter, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module trig_view_asserts
    import cmd_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_ready_o,
    input wire logic tx_valid_o,
    input wire logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    input wire logic trig_criteria_met_i,
    input wire logic mixed_signal_model_i,
    input wire logic selftest_running_i,
    input wire logic selftest_cancel_o,
    input wire logic cmd_error_o,
    input wire logic trig_flag_o,
    input wire view_sel_t shown_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    // --------------------
    // Helpers
    // --------------------
    logic nl_q;

    // Remembers that a message ended on the previous edge
    always_ff @(posedge clk_sys_i) begin
        nl_q <= !sys_rst_i && rx_valid_i && rx_ready_o && (rx_data_i == CH_NL);
    end

    sequence digit_out;
        tx_valid_o && tx_ready_i && (tx_data_o != CH_NL);
    endsequence
    sequence term_next;
        ##1 (tx_valid_o && (tx_data_o == CH_NL));
    endsequence

    // --------------------
    // Assertions
    // --------------------
    AST_FLAG_SOURCE: assert property ($rose(trig_flag_o) |-> $past(trig_criteria_met_i))
        else $error("flag set without a trigger event");
    AST_FLAG_SET: assert property (trig_criteria_met_i |=> trig_flag_o)
        else $error("trigger event did not set the flag");
    AST_FLAG_HOLD: assert property ($fell(trig_flag_o) |-> nl_q)
        else $error("flag cleared outside a message end");
    AST_REPLY_DIGIT: assert property ($rose(tx_valid_o) |->
        tx_data_o == ($past(trig_flag_o) ? CH_ONE : CH_ZERO))
        else $error("reply digit does not match the flag");
    AST_REPLY_ORDER: assert property (digit_out |-> term_next)
        else $error("reply digit not followed by newline");
    AST_REPLY_BLOCKS_RX: assert property (tx_valid_o |-> !rx_ready_o)
        else $error("characters accepted while a reply is pending");
    AST_ERR_KEEPS_VIEW: assert property (cmd_error_o |-> $stable(shown_o))
        else $error("rejected message changed the display");
    AST_VIEW_AT_END: assert property (!$stable(shown_o) |-> nl_q)
        else $error("display changed outside a message end");
    AST_DIG_NEEDS_MIXED: assert property ((shown_o.dig & ~$past(shown_o.dig)) != 16'h0000
        |-> $past(mixed_signal_model_i))
        else $error("digital channel shown on a model without them");
    AST_CANCEL_PULSE: assert property (selftest_cancel_o |->
        ($past(selftest_running_i) && nl_q) ##1 !selftest_cancel_o)
        else $error("bad self-test cancel pulse");
endmodule // trig_view_asserts

bind trig_view_cmd trig_view_asserts trig_view_asserts_inst (.*);
`default_nettype wire

// File: trig_flag_view_selftest_cmds_tb.sv
// Self-checking testbench of the command interpreter
`timescale 1ns/1ps
`default_nettype none
module trig_flag_view_selftest_cmds_tb
    import cmd_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic rx_valid, rx_ready, tx_valid, tx_ready, cancel, cmd_err, flag;
    logic [7:0] rx_data, tx_data;
    logic trig_met = 1'b0;
    logic auto_trig = 1'b0;
    logic mixed = 1'b0;
    logic st_run = 1'b0;
    view_sel_t shown, exp_view;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int err_cnt = 0;
    int cancel_cnt = 0;

    // --------------------
    // Clock, pulse counters and hang guard
    // --------------------
    always #2.5 clk_sys_i = ~clk_sys_i;

    // Counting one-cycle pulses keeps short events from slipping past
    always @(posedge clk_sys_i) begin
        err_cnt += (cmd_err === 1'b1);
        cancel_cnt += (cancel === 1'b1);
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end

    trig_view_cmd trig_view_cmd_inst (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .rx_valid_i(rx_valid),
        .rx_data_i(rx_data), .rx_ready_o(rx_ready), .tx_valid_o(tx_valid),
        .tx_data_o(tx_data), .tx_ready_i(tx_ready), .trig_criteria_met_i(trig_met),
        .auto_trig_i(auto_trig), .mixed_signal_model_i(mixed),
        .selftest_running_i(st_run), .selftest_cancel_o(cancel), .cmd_error_o(cmd_err),
        .trig_flag_o(flag), .shown_o(shown)
    );

    host_model host_model_inst (
        .clk_sys_i(clk_sys_i), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
        .rx_ready_i(rx_ready), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
        .tx_ready_o(tx_ready)
    );

    // --------------------
    // Shared tasks
    // --------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Effects land on the newline edge itself; two further cycles are allowed
    task automatic run_cmd(input string s, input logic exp_err);
        int e0;
        e0 = err_cnt;
        host_model_inst.send(s);
        repeat (2) @(negedge clk_sys_i);
        check({s, " error"}, 32'(err_cnt - e0), {31'h0, exp_err});
        check({s, " view"}, {1'b0, shown}, {1'b0, exp_view});
    endtask

    task automatic query(input logic exp_one);
        int n;
        string hdr;
        hdr = ":T";
        host_model_inst.replies.delete();
        host_model_inst.send({hdr, "ER?"});
        n = 0;
        while (host_model_inst.replies.size() < 2 && n < 50) begin
            @(negedge clk_sys_i);
            n++;
        end
        check("reply count", 32'(host_model_inst.replies.size()), 32'h2);
        check("reply digit", {24'h0, host_model_inst.replies[0]},
              exp_one ? 32'h31 : 32'h30);
        check("reply end", {24'h0, host_model_inst.replies[1]}, 32'h0a);
        check("flag after read", {31'h0, flag}, 32'h0);
    endtask

    task automatic pulse_trig(input logic real_trig);
        @(negedge clk_sys_i);
        trig_met = real_trig;
        auto_trig = ~real_trig;
        @(negedge clk_sys_i);
        trig_met = 1'b0;
        auto_trig = 1'b0;
    endtask

    // --------------------
    // Scenarios
    // --------------------
    task automatic sc_trigger();
        query(1'b0);
        pulse_trig(1'b0);
        check("auto trigger", {31'h0, flag}, 32'h0);
        pulse_trig(1'b1);
        repeat (20) @(negedge clk_sys_i);
        check("flag held", {31'h0, flag}, 32'h1);
        host_model_inst.slow = 1'b1;
        query(1'b1);
        host_model_inst.slow = 1'b0;
        query(1'b0);
        pulse_trig(1'b1);
        run_cmd("*cls", 1'b0);
        check("flag after clear", {31'h0, flag}, 32'h0);
    endtask

    task automatic sc_view();
        string pd;
        pd = "VIEW PO";
        mixed = 1'b1;
        exp_view.chan[1] = 1'b1;
        run_cmd("VIEW CHAN2", 1'b0);
        exp_view.func[3] = 1'b1;
        run_cmd(":view function4", 1'b0);
        exp_view.wmem[0] = 1'b1;
        run_cmd("VIEW WMEM1", 1'b0);
        exp_view.hist = 1'b1;
        run_cmd("View Histogram", 1'b0);
        exp_view.bus[1] = 1'b1;
        run_cmd("VIEW BUS2", 1'b0);
        exp_view.dig[15] = 1'b1;
        run_cmd("VIEW DIGITAL15", 1'b0);
        exp_view.dig[7:0] = 8'hff;
        run_cmd({pd, "D1"}, 1'b0);
        exp_view.dig[15:8] = 8'hff;
        run_cmd({pd, "D2"}, 1'b0);
        exp_view.dig[3:1] = 3'h0;
        exp_view.dig[9] = 1'b0;
        run_cmd("BLANK (@1:3,9)", 1'b0);
        exp_view.chan[1] = 1'b0;
        run_cmd("blan chan2", 1'b0);
        exp_view.dig[15:0] = 16'h0000;
        run_cmd("BLAN (@0:15)", 1'b0);
        exp_view.dig[0] = 1'b1;
        exp_view.dig[14] = 1'b1;
        exp_view.dig[5:3] = 3'h7;
        run_cmd("VIEW (@0,3:5,14)", 1'b0);
    endtask

    task automatic sc_refuse();
        string pd;
        pd = "VIEW PO";
        run_cmd("VIEW CHAN5", 1'b1);
        run_cmd("VIEW FUNC0", 1'b1);
        run_cmd("VIEW BOGUS", 1'b1);
        run_cmd("VIEW (@16)", 1'b1);
        mixed = 1'b0;
        run_cmd("VIEW DIG4", 1'b1);
        run_cmd("VIEW (@1)", 1'b1);
        run_cmd({pd, "D2"}, 1'b1);
    endtask

    task automatic sc_cancel();
        int c0;
        c0 = cancel_cnt;
        st_run = 1'b1;
        run_cmd(":SELF:CANC", 1'b0);
        run_cmd("selftest:cancel", 1'b0);
        check("cancel pulses", 32'(cancel_cnt - c0), 32'h2);
        st_run = 1'b0;
        run_cmd(":SELF:CANC", 1'b0);
        check("cancel when idle", 32'(cancel_cnt - c0), 32'h2);
    endtask

    // --------------------
    // Main sequence
    // --------------------
    initial begin
        exp_view = VIEW_RST;
        repeat (3) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        check("reset flag", {31'h0, flag}, {31'h0, FLAG_RST});
        check("reset view", {1'b0, shown}, 32'h0);
        check("reset ready", {30'h0, rx_ready, tx_valid}, 32'h2);
        sc_trigger();
        sc_view();
        sc_refuse();
        sc_cancel();
        close_out();
    end
endmodule // trig_flag_view_selftest_cmds_tb
`default_nettype wire
